// *** wit_top.sv ***
// watchdog interval timer with guarded registers on an axi4-lite slave
// Functional notes
// - count and control writes refused unless key is 5a or a5
// - key 5a permits one count write
// - key a5 permits one control/status write
// - key clears after count or control write
// - run enable starts upcount at divider rate
// - watchdog overflow resets, counter keeps running
// - reset pulse lasts exactly 64 clocks
// - no new reset while watchdog flag set
// - run enable low freezes, high resumes
// - count write while running reloads, continues up
// - interval overflow raises interrupt, not reset
// - default interval counts from zero to overflow
// - writing one clears interval flag
// - mode bit zero interval, one watchdog
// - counting pauses while debugger halts cpu
// - flags survive the watchdog reset
`include "wit_params.svh"
module wit_top
  import wit_pkg::*;
(
  input  wire logic                   ref_clk_in,     // 250 mhz clock
  input  wire logic                   sys_rst_in,     // sync reset, high
  input  wire logic                   dbg_halt_in,    // debugger halt pin
  input  wire logic [`WIT_ADDR_W-1:0] s_awaddr_in,    // write address
  input  wire logic                   s_awvalid_in,   // write addr valid
  output logic                        s_awready_out,  // write addr ready
  input  wire logic [31:0]            s_wdata_in,     // write data
  input  wire logic [3:0]             s_wstrb_in,     // byte enables
  input  wire logic                   s_wvalid_in,    // write data valid
  output logic                        s_wready_out,   // write data ready
  output logic [1:0]                  s_bresp_out,    // write response
  output logic                        s_bvalid_out,   // response valid
  input  wire logic                   s_bready_in,    // response ready
  input  wire logic [`WIT_ADDR_W-1:0] s_araddr_in,    // read address
  input  wire logic                   s_arvalid_in,   // read addr valid
  output logic                        s_arready_out,  // read addr ready
  output logic [31:0]                 s_rdata_out,    // read data
  output logic [1:0]                  s_rresp_out,    // read response
  output logic                        s_rvalid_out,   // read data valid
  input  wire logic                   s_rready_in,    // read data ready
  output logic                        wdt_rst_out,    // system reset pulse
  output logic                        itv_irq_out     // interval request
);

  // ****************************************************
  // declarations
  // ****************************************************
  localparam logic [`WIT_ADDR_W-1:0] A_CNT = {`WIT_IDX_CNT, 2'b00};
  localparam logic [`WIT_ADDR_W-1:0] A_CSR = {`WIT_IDX_CSR, 2'b00};
  localparam logic [`WIT_ADDR_W-1:0] A_KEY = {`WIT_IDX_KEY, 2'b00};

  wit_wstate_t            wstate;     // write channel state
  logic                   aw_held;    // write address captured
  logic                   w_held;     // write data captured
  logic [`WIT_ADDR_W-1:0] aw_addr;    // captured write address
  logic [7:0]             w_data;     // captured low data byte
  logic                   w_lane0;    // low byte lane enabled
  logic                   wr_go;      // write performed this cycle
  logic                   wr_map;     // write address decodes
  logic                   cnt_wr;     // accepted count write
  logic                   csr_wr;     // accepted control write
  logic                   key_wr;     // key register write
  logic                   guard_hit;  // low-lane write to guarded regs
  logic [7:0]             cnt;        // count_register
  logic [7:0]             key;        // access_guard_key
  wit_csr_t               csr;        // control_status_register
  logic                   tick;       // divided count enable
  logic                   tick_ok;    // tick gated by run and halt
  logic                   ovf;        // counter wraps this cycle
  logic [6:0]             rst_cnt;    // reset pulse cycles left
  logic                   h1, h2, h3; // halt pin synchroniser
  logic                   halt_s;     // filtered halt level
  logic [31:0]            rd_mux;     // read data selection
  logic                   rd_map;     // read address decodes

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  // ****************************************************
  // axi4-lite write channel
  // ****************************************************
  // address and data are taken in either order and held
  // until both are present; the register action happens in
  // the cycle both are held, the response one edge later
  assign wr_go = aw_held && w_held && (wstate == WIT_WS_IDLE);

  // address capture
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_awvalid_in && s_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_awaddr_in;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  // data capture, only the low lane carries register bits
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      w_held  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_wvalid_in && s_wready_out) begin
      w_held  <= 1'b1;
      w_data  <= s_wdata_in[7:0];
      w_lane0 <= s_wstrb_in[0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // ready stays low while an item is held or a response waits
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s_awready_out <= 1'b0;
      s_wready_out  <= 1'b0;
    end else begin
      s_awready_out <= !(aw_held || (s_awvalid_in && s_awready_out))
                       && (wstate == WIT_WS_IDLE) && !wr_go;
      s_wready_out  <= !(w_held || (s_wvalid_in && s_wready_out))
                       && (wstate == WIT_WS_IDLE) && !wr_go;
    end
  end

  // address decode for the write side
  always_comb begin
    if (aw_addr == A_CNT) begin
      wr_map = 1'b1;
    end else if (aw_addr == A_CSR) begin
      wr_map = 1'b1;
    end else if (aw_addr == A_KEY) begin
      wr_map = 1'b1;
    end else begin
      wr_map = 1'b0;
    end
  end

  // response state machine
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wstate       <= WIT_WS_IDLE;
      s_bvalid_out <= 1'b0;
      s_bresp_out  <= `WIT_RESP_OK;
    end else begin
      case (wstate)
        WIT_WS_IDLE: begin
          if (wr_go) begin
            wstate       <= WIT_WS_RESP;
            s_bvalid_out <= 1'b1;
            s_bresp_out  <= wr_map ? `WIT_RESP_OK : `WIT_RESP_ERR;
          end
        end
        WIT_WS_RESP: begin
          if (s_bready_in) begin
            wstate       <= WIT_WS_IDLE;
            s_bvalid_out <= 1'b0;
          end
        end
        default: begin
          wstate       <= WIT_WS_IDLE;
          s_bvalid_out <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // guard key
  // ****************************************************
  // a refused guarded write still answers okay; it simply
  // leaves the register untouched
  assign guard_hit = wr_go && w_lane0 &&
                     (aw_addr == A_CNT || aw_addr == A_CSR);
  assign cnt_wr = guard_hit && (aw_addr == A_CNT) &&
                  (key == `WIT_KEY_CNT);
  assign csr_wr = guard_hit && (aw_addr == A_CSR) &&
                  (key == `WIT_KEY_CSR);
  assign key_wr = wr_go && w_lane0 && (aw_addr == A_KEY);

  // key holds one permission; any guarded low-lane write spends it
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      key <= `WIT_KEY_INIT;
    end else if (guard_hit) begin
      key <= `WIT_KEY_INIT;
    end else if (key_wr) begin
      key <= w_data;
    end
  end

  property p_key_clr; guard_hit |=> key == `WIT_KEY_INIT; endproperty
  a_key_clr: assert property (p_key_clr)
    else $error("guard key not cleared after guarded write");

  // ****************************************************
  // debugger halt synchroniser
  // ****************************************************
  // level changes only once the two later stages agree
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      h1     <= 1'b0;
      h2     <= 1'b0;
      h3     <= 1'b0;
      halt_s <= 1'b0;
    end else begin
      h1 <= dbg_halt_in;
      h2 <= h1;
      h3 <= h2;
      if (h2 == h3) begin
        halt_s <= h3;
      end
    end
  end

  // ****************************************************
  // counter
  // ****************************************************
  wit_prescaler u_prescaler (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (csr.run && !halt_s),
    .div_sel_in (csr.div_sel),
    .tick_out   (tick)
  );

  assign tick_ok = tick && csr.run && !halt_s;
  assign ovf     = tick_ok && (cnt == `WIT_CNT_MAX) && !cnt_wr;

  // a software load beats a tick in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt <= `WIT_CNT_INIT;
    end else if (cnt_wr) begin
      cnt <= w_data;
    end else if (tick_ok) begin
      cnt <= cnt + 8'h01;
    end
  end

  property p_cnt_load; cnt_wr |=> cnt == $past(w_data); endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("permitted count write not loaded");
  property p_refuse;
    wr_go && aw_addr == A_CNT && key != `WIT_KEY_CNT && !tick_ok
    |=> cnt == $past(cnt);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("count changed without key");
  property p_count_up;
    tick_ok && !cnt_wr |=> cnt == $past(cnt) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not step on tick");
  property p_freeze;
    (!csr.run || halt_s) && !cnt_wr |=> cnt == $past(cnt);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter moved while stopped or halted");

  // ****************************************************
  // control/status register and flags
  // ****************************************************
  // flags are cleared only by this block's own reset or a written one,
  // never by the reset pulse it drives out; a set beats a clear
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      csr <= '0;
    end else begin
      if (csr_wr) begin
        csr.run     <= w_data[`WIT_B_RUN];
        csr.wdog    <= w_data[`WIT_B_MODE];
        csr.div_sel <= w_data[`WIT_B_DIV_HI:`WIT_B_DIV_LO];
      end
      if (ovf && csr.wdog) begin
        csr.wd_flag <= 1'b1;
      end else if (csr_wr && w_data[`WIT_B_WDF]) begin
        csr.wd_flag <= 1'b0;
      end
      if (ovf && !csr.wdog) begin
        csr.iv_flag <= 1'b1;
      end else if (csr_wr && w_data[`WIT_B_IVF]) begin
        csr.iv_flag <= 1'b0;
      end
    end
  end

  property p_csr_load;
    csr_wr |=> csr.run == $past(w_data[`WIT_B_RUN])
           && csr.wdog == $past(w_data[`WIT_B_MODE])
           && csr.div_sel == $past(w_data[`WIT_B_DIV_HI:`WIT_B_DIV_LO]);
  endproperty
  a_csr_load: assert property (p_csr_load)
    else $error("permitted control write not loaded");
  property p_wd_flag; ovf && csr.wdog |=> csr.wd_flag; endproperty
  a_wd_flag: assert property (p_wd_flag)
    else $error("watchdog flag not set on overflow");
  // the interval flag must set even when an old watchdog flag stands
  property p_iv_flag;
    ovf && !csr.wdog
    |=> csr.iv_flag && (!csr.wd_flag || $past(csr.wd_flag));
  endproperty
  a_iv_flag: assert property (p_iv_flag)
    else $error("interval overflow misflagged");

  // ****************************************************
  // watchdog reset pulse and interval request
  // ****************************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rst_cnt     <= 7'd0;
      wdt_rst_out <= 1'b0;
    end else if (ovf && csr.wdog && !csr.wd_flag) begin
      rst_cnt     <= `WIT_RST_CLKS;
      wdt_rst_out <= 1'b1;
    end else if (rst_cnt != 7'd0) begin
      rst_cnt     <= rst_cnt - 7'd1;
      wdt_rst_out <= (rst_cnt != 7'd1);
    end
  end

  // request follows the flag so it stays until software clears it
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      itv_irq_out <= 1'b0;
    end else begin
      itv_irq_out <= csr.iv_flag;
    end
  end

  sequence s_rst_fire;
    ovf && csr.wdog && !csr.wd_flag;
  endsequence
  sequence s_rst_body;
    wdt_rst_out ##63 wdt_rst_out ##1 !wdt_rst_out;
  endsequence
  property p_rst_len; s_rst_fire |=> s_rst_body; endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("watchdog reset pulse not 64 clocks");
  property p_no_rerst;
    ovf && csr.wd_flag && !wdt_rst_out |=> !wdt_rst_out;
  endproperty
  a_no_rerst: assert property (p_no_rerst)
    else $error("reset repeated while flag set");

  // ****************************************************
  // axi4-lite read channel
  // ****************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    if (s_araddr_in == A_CNT) begin
      rd_mux[7:0] = cnt;
    end else if (s_araddr_in == A_CSR) begin
      rd_mux[`WIT_B_RUN]                    = csr.run;
      rd_mux[`WIT_B_MODE]                   = csr.wdog;
      rd_mux[`WIT_B_WDF]                    = csr.wd_flag;
      rd_mux[`WIT_B_IVF]                    = csr.iv_flag;
      rd_mux[`WIT_B_DIV_HI:`WIT_B_DIV_LO]   = csr.div_sel;
    end else if (s_araddr_in == A_KEY) begin
      rd_mux[7:0] = key;
    end else begin
      rd_map = 1'b0;
    end
  end

  // one read at a time; ready drops while data waits
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s_arready_out <= 1'b0;
      s_rvalid_out  <= 1'b0;
      s_rdata_out   <= 32'h0000_0000;
      s_rresp_out   <= `WIT_RESP_OK;
    end else if (s_arvalid_in && s_arready_out) begin
      s_arready_out <= 1'b0;
      s_rvalid_out  <= 1'b1;
      s_rdata_out   <= rd_mux;
      s_rresp_out   <= rd_map ? `WIT_RESP_OK : `WIT_RESP_ERR;
    end else if (s_rvalid_out) begin
      if (s_rready_in) begin
        s_rvalid_out  <= 1'b0;
        s_arready_out <= 1'b1;
      end
    end else begin
      s_arready_out <= 1'b1;
    end
  end

endmodule : wit_top

// *** wit_params.svh ***
// constants of the watchdog interval timer: offsets, fields, keys, timings
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH

// ****************************************************
// register indices; byte address is four times these
// ****************************************************
`define WIT_IDX_CNT     16'hfe80
`define WIT_IDX_CSR     16'hfe81
`define WIT_IDX_KEY     16'hfe82
`define WIT_ADDR_W      18

// ****************************************************
// reset values and key codes
// ****************************************************
`define WIT_CNT_INIT    8'h00
`define WIT_KEY_INIT    8'h00
`define WIT_KEY_CNT     8'h5a
`define WIT_KEY_CSR     8'ha5
`define WIT_CNT_MAX     8'hff

// ****************************************************
// control/status bit positions
// ****************************************************
`define WIT_B_RUN       7
`define WIT_B_MODE      6
`define WIT_B_WDF       4
`define WIT_B_IVF       3
`define WIT_B_DIV_HI    2
`define WIT_B_DIV_LO    0

// ****************************************************
// timing: reset pulse length and divider shape
// ****************************************************
`define WIT_RST_CLKS    7'd64
`define WIT_DIV_BASE    4'h1
`define WIT_DIV_STEP    4'h2

// ****************************************************
// bus responses
// ****************************************************
`define WIT_RESP_OK     2'b00
`define WIT_RESP_ERR    2'b10

`endif

// *** wit_pkg.sv ***
// types shared by the watchdog interval timer files
package wit_pkg;

  // ****************************************************
  // control/status register image
  // ****************************************************
  typedef struct packed {
    logic       run;      // timer_run_enable
    logic       wdog;     // mode_select, 1 = watchdog
    logic       wd_flag;  // watchdog_overflow_flag
    logic       iv_flag;  // interval_overflow_flag
    logic [2:0] div_sel;  // clock_divider_select
  } wit_csr_t;

  // write channel states, one-hot
  typedef enum logic [1:0] {
    WIT_WS_IDLE = 2'b01,
    WIT_WS_RESP = 2'b10
  } wit_wstate_t;

endpackage : wit_pkg

// *** wit_prescaler.sv ***
// count clock divider: one-cycle tick at the selected division ratio
`include "wit_params.svh"
module wit_prescaler
  import wit_pkg::*;
(
  input  wire logic       ref_clk_in,  // fast system clock
  input  wire logic       sys_rst_in,  // sync reset, active high
  input  wire logic       run_in,      // divider runs while high
  input  wire logic [2:0] div_sel_in,  // clock_divider_select
  output logic            tick_out     // one-cycle count enable
);

  logic [15:0] div_cnt;   // free divider count
  logic [3:0]  shift;     // log2 of division ratio
  logic [15:0] mask;      // low bits that must be all ones

  // ratio is 2^(base + step*cks)
  always_comb begin
    shift = 4'(`WIT_DIV_BASE + `WIT_DIV_STEP * {1'b0, div_sel_in});
    mask  = 16'((17'h1 << shift) - 17'h1);
  end

  // ****************************************************
  // divider count
  // ****************************************************
  // held at zero while stopped so a restart sees a full period
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !run_in) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // tick registered so the counter sees a clean enable
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !run_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= ((div_cnt & mask) == mask);
    end
  end

endmodule : wit_prescaler

// *** wit_tb.sv ***
// self-checking bus-level testbench for the watchdog interval timer
`include "wit_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************
  // stimulus and observed signals
  // ****************************************************
  logic                   ref_clk_in;   // 250 mhz clock
  logic                   sys_rst_in;   // sync reset
  logic                   dbg_halt_in;  // debugger halt
  logic [`WIT_ADDR_W-1:0] s_awaddr;     // write address
  logic [`WIT_ADDR_W-1:0] s_araddr;     // read address
  logic                   s_awvalid, s_awready, s_wvalid, s_wready;
  logic                   s_bvalid, s_bready, s_arvalid, s_arready;
  logic                   s_rvalid, s_rready;
  logic [31:0]            s_wdata, s_rdata;  // data buses
  logic [3:0]             s_wstrb;      // byte enables
  logic [1:0]             s_bresp, s_rresp;  // responses
  logic                   wdt_rst, itv_irq;  // timer outputs
  int                     fails;        // mismatches
  int                     n_checks;     // comparisons
  logic [1:0]             rsp;          // last response
  logic [7:0]             rv, v1;       // read values
  int                     n;            // cycle count
  logic                   seen;         // event flag

  localparam logic [17:0] A_CNT = {`WIT_IDX_CNT, 2'b00};
  localparam logic [17:0] A_CSR = {`WIT_IDX_CSR, 2'b00};
  localparam logic [17:0] A_KEY = {`WIT_IDX_KEY, 2'b00};
  localparam logic [17:0] A_BAD = 18'h3fa0c;  // unmapped word

  `define CHK(a, e) check_val(32'(a), 32'(e))

  wit_top i_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .dbg_halt_in(dbg_halt_in),
    .s_awaddr_in(s_awaddr), .s_awvalid_in(s_awvalid),
    .s_awready_out(s_awready), .s_wdata_in(s_wdata),
    .s_wstrb_in(s_wstrb), .s_wvalid_in(s_wvalid),
    .s_wready_out(s_wready), .s_bresp_out(s_bresp),
    .s_bvalid_out(s_bvalid), .s_bready_in(s_bready),
    .s_araddr_in(s_araddr), .s_arvalid_in(s_arvalid),
    .s_arready_out(s_arready), .s_rdata_out(s_rdata),
    .s_rresp_out(s_rresp), .s_rvalid_out(s_rvalid),
    .s_rready_in(s_rready), .wdt_rst_out(wdt_rst),
    .itv_irq_out(itv_irq)
  );

  // ****************************************************
  // clock
  // ****************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************************
  // report helpers
  // ****************************************************
  task automatic check_val(input logic [31:0] a, input logic [31:0] e);
    n_checks++;
    if (a !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : check_val

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // a hang counts as a mismatch and ends the run
  task automatic hang(input int k);
    if (k > 200) begin
      fails++;
      complete_run();
    end
  endtask : hang

  // ****************************************************
  // axi4-lite master: both write channels offered together
  // ****************************************************
  task automatic wr(input logic [17:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int   k;
    logic aw_ok, w_ok, b_ok;
    k = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge ref_clk_in);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {24'h000000, d};
    s_wstrb <= 4'h1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!b_ok) begin
      @(posedge ref_clk_in);
      k++;
      // release each channel at the edge that takes it
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid === 1'b1) begin
        b_ok = 1'b1;
        r = s_bresp;
        s_bready <= 1'b0;
      end
      hang(k);
    end
  endtask : wr

  task automatic rd(input logic [17:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    int   k;
    logic ar_ok, r_ok;
    k = 0;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge ref_clk_in);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!r_ok) begin
      @(posedge ref_clk_in);
      k++;
      if (!ar_ok && s_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid === 1'b1) begin
        r_ok = 1'b1;
        d = s_rdata[7:0];
        r = s_rresp;
        s_rready <= 1'b0;
      end
      hang(k);
    end
  endtask : rd

  // ****************************************************
  // register level helpers; guarded writes load the key first
  // ****************************************************
  task automatic rdchk(input logic [17:0] a, input logic [7:0] e);
    rd(a, rv, rsp);
    `CHK(rv, e);
    `CHK(rsp, `WIT_RESP_OK);
  endtask : rdchk

  task automatic wcnt(input logic [7:0] v);
    wr(A_KEY, `WIT_KEY_CNT, rsp);
    wr(A_CNT, v, rsp);
  endtask : wcnt

  task automatic wcsr(input logic [7:0] v);
    wr(A_KEY, `WIT_KEY_CSR, rsp);
    wr(A_CSR, v, rsp);
  endtask : wcsr

  // wait for the request (sel 0) or the reset pulse (sel 1)
  task automatic wait_out(input logic sel, output int k);
    k = 0;
    while ((sel ? wdt_rst : itv_irq) !== 1'b1) begin
      @(posedge ref_clk_in);
      k++;
      if (k > 1000) begin
        fails++;
        complete_run();
      end
    end
  endtask : wait_out

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    fails = 0;
    n_checks = 0;
    sys_rst_in = 1'b1;
    dbg_halt_in = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = '0;
    s_araddr = '0;
    s_wdata = 32'h00000000;
    s_wstrb = 4'h0;
    repeat (10) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rdchk(A_CNT, `WIT_CNT_INIT);
    rdchk(A_CSR, 8'h00);
    rdchk(A_KEY, `WIT_KEY_INIT);
    // no key, wrong key and crossed key are all refused
    wr(A_CNT, 8'h33, rsp);
    rdchk(A_CNT, 8'h00);
    wr(A_KEY, 8'h11, rsp);
    wr(A_CSR, 8'h80, rsp);
    rdchk(A_CSR, 8'h00);
    rdchk(A_KEY, 8'h00);
    wr(A_KEY, `WIT_KEY_CSR, rsp);
    wr(A_CNT, 8'h44, rsp);
    rdchk(A_CNT, 8'h00);
    wcnt(8'h80);
    rdchk(A_CNT, 8'h80);
    rdchk(A_KEY, 8'h00);
    // unmapped word answers with an error
    wr(A_BAD, 8'h12, rsp);
    `CHK(rsp, `WIT_RESP_ERR);
    rd(A_BAD, rv, rsp);
    `CHK({rsp, rv}, {`WIT_RESP_ERR, 8'h00});
    // every divider select, stopped
    for (int i = 0; i < 8; i++) begin
      wcsr(8'(i));
      rdchk(A_CSR, 8'(i));
    end
    // default interval: 256 ticks of 2 cycles from zero
    wcnt(8'h00);
    wcsr(8'h80);
    wait_out(1'b0, n);
    `CHK(n >= 500 && n <= 530, 1);
    `CHK(wdt_rst, 1'b0);
    rdchk(A_CSR, 8'h88);
    wcsr(8'h88);
    rdchk(A_CSR, 8'h80);
    `CHK(itv_irq, 1'b0);
    // reload while running shortens the next interval
    wcnt(8'hf8);
    wait_out(1'b0, n);
    `CHK(n < 40, 1);
    // stop freezes, restart resumes
    wcsr(8'h08);
    rd(A_CNT, v1, rsp);
    repeat (40) @(posedge ref_clk_in);
    rdchk(A_CNT, v1);
    wcsr(8'h80);
    repeat (20) @(posedge ref_clk_in);
    rd(A_CNT, rv, rsp);
    `CHK(rv != v1, 1);
    // debugger halt pauses counting
    dbg_halt_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    rd(A_CNT, v1, rsp);
    repeat (40) @(posedge ref_clk_in);
    rdchk(A_CNT, v1);
    dbg_halt_in <= 1'b0;
    // watchdog mode: one 64-cycle pulse, counter keeps going
    wcsr(8'h08);
    wcnt(8'hfc);
    wcsr(8'hc0);
    wait_out(1'b1, n);
    n = 0;
    while (wdt_rst === 1'b1 && n < 200) begin
      n++;
      @(posedge ref_clk_in);
    end
    `CHK(n, 64);
    rd(A_CNT, rv, rsp);
    `CHK(rv > 8'h10, 1);
    rdchk(A_CSR, 8'hd0);
    `CHK(itv_irq, 1'b0);
    // a later overflow with the flag still set is silent
    seen = 1'b0;
    repeat (600) begin
      @(posedge ref_clk_in);
      seen = seen | (wdt_rst !== 1'b0);
    end
    `CHK(seen, 1'b0);
    wcsr(8'hd0);
    rdchk(A_CSR, 8'hc0);
    // periodic reloads keep the watchdog from firing; without them
    // the counter would wrap inside these 450 cycles
    seen = 1'b0;
    repeat (3) begin
      wcnt(8'h80);
      repeat (150) begin
        @(posedge ref_clk_in);
        seen = seen | (wdt_rst !== 1'b0);
      end
    end
    `CHK(seen, 1'b0);
    wcnt(8'hf0);
    wait_out(1'b1, n);
    `CHK(n < 60, 1);
    complete_run();
  end
endmodule : testbench
